// ===== design/hss_pkg.sv
// Package with the register map, field layout and timing constants of the switch drive block.
package hss_pkg;
	localparam logic [7:0] ADDR_SWITCH_CONTROL = 8'h1E;
	localparam logic [7:0] ADDR_PWM_A_RATE = 8'h1F;
	localparam logic [7:0] ADDR_PWM_A_DUTY_HIGH = 8'h20;
	localparam logic [7:0] ADDR_PWM_A_DUTY_LOW = 8'h21;
	localparam logic [7:0] ADDR_PWM_B_RATE = 8'h22;
	localparam logic [7:0] ADDR_PWM_B_DUTY_HIGH = 8'h23;
	localparam logic [7:0] ADDR_PWM_B_DUTY_LOW = 8'h24;
	localparam logic [7:0] ADDR_PERIODIC_A = 8'h25;
	localparam logic [7:0] ADDR_PERIODIC_B = 8'h26;

	localparam int ENABLE_BIT = 7;
	localparam int SEL_MSB = 6;
	localparam int SEL_LSB = 4;
	localparam int RATE_BIT = 7;
	localparam int WIDTH_MSB = 7;
	localparam int WIDTH_LSB = 4;
	localparam int PERIOD_MSB = 2;
	localparam int PERIOD_LSB = 0;

	localparam logic [7:0] MASK_SWITCH_CONTROL = 8'hF0;
	localparam logic [7:0] MASK_RATE = 8'h80;
	localparam logic [7:0] MASK_DUTY_HIGH = 8'h03;
	localparam logic [7:0] MASK_DUTY_LOW = 8'hFF;
	localparam logic [7:0] MASK_PERIODIC = 8'hF7;
	localparam logic [7:0] RESET_VALUE = 8'h00;

	localparam logic [2:0] SRC_STATIC = 3'h0;
	localparam logic [2:0] SRC_PWM_A = 3'h1;
	localparam logic [2:0] SRC_PWM_B = 3'h2;
	localparam logic [2:0] SRC_PERIODIC_A = 3'h3;
	localparam logic [2:0] SRC_PERIODIC_B = 3'h4;
	localparam logic [2:0] SRC_PIN = 3'h5;

	localparam logic [3:0] WIDTH_OFF = 4'h0;
	localparam logic [3:0] WIDTH_FULL = 4'hF;
	localparam logic [9:0] DUTY_FULL = 10'h3FF;

	localparam int CLK_HZ = 100_000_000;
	localparam int CLK_PERIOD_NS = 10;
	localparam int PWM_RATE_LO_HZ = 200;
	localparam int PWM_RATE_HI_HZ = 400;
	localparam int PWM_STEPS = 1024;
	localparam int PWM_STEP_LO = CLK_HZ / (PWM_RATE_LO_HZ * PWM_STEPS);
	localparam int PWM_STEP_HI = CLK_HZ / (PWM_RATE_HI_HZ * PWM_STEPS);
	localparam int TIMER_TICK_NS = 100_000;
	localparam int TIMER_TICK_CYCLES = TIMER_TICK_NS / CLK_PERIOD_NS;

	typedef struct packed {
		logic wr;
		logic [7:0] addr;
		logic [7:0] wdata;
	} reg_req_t;

	typedef struct packed {
		logic [7:0] ctrl;
		logic [7:0] pa_rate;
		logic [7:0] pa_hi;
		logic [7:0] pa_lo;
		logic [7:0] pb_rate;
		logic [7:0] pb_hi;
		logic [7:0] pb_lo;
		logic [7:0] ta_cfg;
		logic [7:0] tb_cfg;
		logic [2:0] sel_act;
		logic [8:0] pa_pre;
		logic [9:0] pa_cnt;
		logic [8:0] pb_pre;
		logic [9:0] pb_cnt;
		logic [13:0] tick_pre;
		logic [14:0] ta_cnt;
		logic [14:0] tb_cnt;
		logic pin_s1;
		logic pin_s2;
		logic on;
		logic hiz;
		logic [7:0] rdata;
	} state_t;
endpackage

// ===== design/high_side_switch_pwm_control.sv
// Register-controlled source selection and PWM/periodic drive for the high-side switch.
// Operation
// [RQ1] Enable bit 7 gates switch; reset clears.
// [RQ2] 3-bit selector picks static, PWM, timer, pin.
// [RQ3] Pin source selected disables failsafe output.
// [RQ4] Rate bit selects 200 or 400 Hz.
// [RQ5] PWM A duty: two upper, eight lower.
// [RQ6] Zero duty off, all ones fully on.
// [RQ7] PWM B duty split the same way.
// [RQ8] Software avoids tiny unrealisable duty values.
// [RQ9] Timer period code 10 ms to 2000 ms.
// [RQ10] Timer on-width code; 0 high-z, F on.
// [RQ11] Disabled keeps off; selector applies at boundary.
module high_side_switch_pwm_control
	import hss_pkg::*;
#(
	parameter int TICK_CYCLES = TIMER_TICK_CYCLES
)
(
	// Clock and reset.
	input wire logic clk_i,
	input wire logic rst_b_i,
	// Register access from the serial control port.
	input wire hss_pkg::reg_req_t req_i,
	output logic [7:0] rdata_o,
	// Control pin and switch drive.
	input wire logic switch_control_pin_i,
	output logic switch_on_o,
	output logic switch_high_z_o,
	output logic failsafe_output_disable_o
);
	import hss_pkg::*;

	state_t st_reg;
	state_t st_next;
	logic boundary;
	logic pa_wrap;
	logic pb_wrap;
	logic ta_wrap;
	logic tb_wrap;
	logic tick;

	function automatic logic [14:0] period_ticks(input logic [2:0] code);
		case (code)
			3'h0: period_ticks = 15'd100;
			3'h1: period_ticks = 15'd200;
			3'h2: period_ticks = 15'd500;
			3'h3: period_ticks = 15'd1000;
			3'h4: period_ticks = 15'd2000;
			3'h5: period_ticks = 15'd5000;
			3'h6: period_ticks = 15'd10000;
			default: period_ticks = 15'd20000;
		endcase
	endfunction

	function automatic logic [14:0] width_ticks(input logic [3:0] code);
		case (code)
			4'h1: width_ticks = 15'd1;
			4'h2: width_ticks = 15'd3;
			4'h3: width_ticks = 15'd5;
			4'h4: width_ticks = 15'd10;
			4'h5: width_ticks = 15'd100;
			4'h6: width_ticks = 15'd200;
			4'h7: width_ticks = 15'd300;
			4'h8: width_ticks = 15'd400;
			4'h9: width_ticks = 15'd500;
			4'hA: width_ticks = 15'd600;
			4'hB: width_ticks = 15'd800;
			4'hC: width_ticks = 15'd1000;
			4'hD: width_ticks = 15'd1500;
			4'hE: width_ticks = 15'd2000;
			default: width_ticks = 15'd0;
		endcase
	endfunction

	// Full-scale duty forces the output on so that no off step remains in the period.
	function automatic logic pwm_level(input logic [9:0] cnt, input logic [9:0] duty);
		pwm_level = (duty == DUTY_FULL) || (cnt < duty);
	endfunction

	function automatic logic timer_level(input logic [14:0] cnt, input logic [3:0] code);
		timer_level = (code == WIDTH_FULL) || (cnt < width_ticks(code));
	endfunction

	function automatic logic [8:0] step_len(input logic rate);
		step_len = rate ? 9'(PWM_STEP_HI - 1) : 9'(PWM_STEP_LO - 1);
	endfunction

	always_comb
	begin
		logic [9:0] duty_a;
		logic [9:0] duty_b;
		logic [14:0] per_a;
		logic [14:0] per_b;
		logic [3:0] wid_a;
		logic [3:0] wid_b;
		logic level;
		logic high_z;
		level = 1'b0;
		high_z = 1'b0;
		duty_a = {st_reg.pa_hi[1:0], st_reg.pa_lo}; // [RQ5]
		duty_b = {st_reg.pb_hi[1:0], st_reg.pb_lo}; // [RQ7]
		per_a = period_ticks(st_reg.ta_cfg[PERIOD_MSB:PERIOD_LSB]); // [RQ9]
		per_b = period_ticks(st_reg.tb_cfg[PERIOD_MSB:PERIOD_LSB]); // [RQ9]
		wid_a = st_reg.ta_cfg[WIDTH_MSB:WIDTH_LSB];
		wid_b = st_reg.tb_cfg[WIDTH_MSB:WIDTH_LSB];
		st_next = st_reg;

		// Register writes; reserved bits are masked and read back as zero.
		if (req_i.wr)
		begin
			case (req_i.addr)
				ADDR_SWITCH_CONTROL: st_next.ctrl = req_i.wdata & MASK_SWITCH_CONTROL;
				ADDR_PWM_A_RATE: st_next.pa_rate = req_i.wdata & MASK_RATE;
				ADDR_PWM_A_DUTY_HIGH: st_next.pa_hi = req_i.wdata & MASK_DUTY_HIGH;
				ADDR_PWM_A_DUTY_LOW: st_next.pa_lo = req_i.wdata & MASK_DUTY_LOW;
				ADDR_PWM_B_RATE: st_next.pb_rate = req_i.wdata & MASK_RATE;
				ADDR_PWM_B_DUTY_HIGH: st_next.pb_hi = req_i.wdata & MASK_DUTY_HIGH;
				ADDR_PWM_B_DUTY_LOW: st_next.pb_lo = req_i.wdata & MASK_DUTY_LOW;
				ADDR_PERIODIC_A: st_next.ta_cfg = req_i.wdata & MASK_PERIODIC;
				ADDR_PERIODIC_B: st_next.tb_cfg = req_i.wdata & MASK_PERIODIC;
				default: st_next.ctrl = st_reg.ctrl;
			endcase
		end

		// Read data is registered; unmapped addresses read zero.
		case (req_i.addr)
			ADDR_SWITCH_CONTROL: st_next.rdata = st_reg.ctrl;
			ADDR_PWM_A_RATE: st_next.rdata = st_reg.pa_rate;
			ADDR_PWM_A_DUTY_HIGH: st_next.rdata = st_reg.pa_hi;
			ADDR_PWM_A_DUTY_LOW: st_next.rdata = st_reg.pa_lo;
			ADDR_PWM_B_RATE: st_next.rdata = st_reg.pb_rate;
			ADDR_PWM_B_DUTY_HIGH: st_next.rdata = st_reg.pb_hi;
			ADDR_PWM_B_DUTY_LOW: st_next.rdata = st_reg.pb_lo;
			ADDR_PERIODIC_A: st_next.rdata = st_reg.ta_cfg;
			ADDR_PERIODIC_B: st_next.rdata = st_reg.tb_cfg;
			default: st_next.rdata = RESET_VALUE;
		endcase

		// PWM step prescalers and 1024-step period counters.
		pa_wrap = 1'b0;
		pb_wrap = 1'b0;
		if (st_reg.pa_pre == 9'h0)
		begin
			st_next.pa_pre = step_len(st_reg.pa_rate[RATE_BIT]); // [RQ4]
			st_next.pa_cnt = st_reg.pa_cnt + 10'h1;
			pa_wrap = (st_reg.pa_cnt == DUTY_FULL);
		end
		else
			st_next.pa_pre = st_reg.pa_pre - 9'h1;
		if (st_reg.pb_pre == 9'h0)
		begin
			st_next.pb_pre = step_len(st_reg.pb_rate[RATE_BIT]); // [RQ4]
			st_next.pb_cnt = st_reg.pb_cnt + 10'h1;
			pb_wrap = (st_reg.pb_cnt == DUTY_FULL);
		end
		else
			st_next.pb_pre = st_reg.pb_pre - 9'h1;

		// Shared 0.1 ms tick for the periodic sources.
		tick = (st_reg.tick_pre == 14'h0);
		st_next.tick_pre = tick ? 14'(TICK_CYCLES - 1) : st_reg.tick_pre - 14'h1;
		ta_wrap = tick && (st_reg.ta_cnt >= per_a - 15'h1);
		tb_wrap = tick && (st_reg.tb_cnt >= per_b - 15'h1);
		if (tick)
		begin
			st_next.ta_cnt = ta_wrap ? 15'h0 : st_reg.ta_cnt + 15'h1; // [RQ9]
			st_next.tb_cnt = tb_wrap ? 15'h0 : st_reg.tb_cnt + 15'h1; // [RQ9]
		end

		st_next.pin_s1 = switch_control_pin_i;
		st_next.pin_s2 = st_reg.pin_s1;

		// A new selector takes over at the active PWM or timer source's period boundary, at once from any other source.
		case (st_reg.sel_act)
			SRC_PWM_A: boundary = pa_wrap;
			SRC_PWM_B: boundary = pb_wrap;
			SRC_PERIODIC_A: boundary = ta_wrap;
			SRC_PERIODIC_B: boundary = tb_wrap;
			default: boundary = 1'b1;
		endcase
		if (boundary)
			st_next.sel_act = st_reg.ctrl[SEL_MSB:SEL_LSB]; // [RQ11]

		case (st_reg.sel_act) // [RQ2]
			SRC_STATIC: level = 1'b1;
			SRC_PWM_A: level = pwm_level(st_reg.pa_cnt, duty_a); // [RQ6]
			SRC_PWM_B: level = pwm_level(st_reg.pb_cnt, duty_b); // [RQ6]
			SRC_PERIODIC_A:
			begin
				level = timer_level(st_reg.ta_cnt, wid_a); // [RQ10]
				high_z = (wid_a == WIDTH_OFF); // [RQ10]
			end
			SRC_PERIODIC_B:
			begin
				level = timer_level(st_reg.tb_cnt, wid_b); // [RQ10]
				high_z = (wid_b == WIDTH_OFF); // [RQ10]
			end
			SRC_PIN: level = st_reg.pin_s2;
			default: level = 1'b0;
		endcase
		st_next.on = st_reg.ctrl[ENABLE_BIT] && level; // [RQ1] [RQ11]
		st_next.hiz = !st_next.on && (!st_reg.ctrl[ENABLE_BIT] || high_z);
	end

	always_ff @(posedge clk_i)
	begin
		if (!rst_b_i)
		begin
			st_reg <= '0; // [RQ1]
			st_reg.hiz <= 1'b1;
			// Prescalers start a full step long so the first PWM step after reset is not cut short.
			st_reg.pa_pre <= 9'(PWM_STEP_LO - 1); // [RQ4]
			st_reg.pb_pre <= 9'(PWM_STEP_LO - 1); // [RQ4]
		end
		else
			st_reg <= st_next;
	end

	assign rdata_o = st_reg.rdata;
	assign switch_on_o = st_reg.on;
	assign switch_high_z_o = st_reg.hiz;
	assign failsafe_output_disable_o = (st_reg.ctrl[SEL_MSB:SEL_LSB] == SRC_PIN); // [RQ3]

	property p_disabled_off;
		@(posedge clk_i) disable iff (!rst_b_i)
		!st_reg.ctrl[ENABLE_BIT] |=> !switch_on_o && switch_high_z_o;
	endproperty
	a_disabled_off: assert property (p_disabled_off) else $error("switch on while disabled"); // [RQ1]

	property p_pin_follow;
		@(posedge clk_i) disable iff (!rst_b_i)
		st_reg.ctrl[ENABLE_BIT] && st_reg.sel_act == SRC_PIN |=> switch_on_o == $past(st_reg.pin_s2);
	endproperty
	a_pin_follow: assert property (p_pin_follow) else $error("pin source not followed"); // [RQ2]

	property p_failsafe;
		@(posedge clk_i) disable iff (!rst_b_i)
		req_i.wr && req_i.addr == ADDR_SWITCH_CONTROL && req_i.wdata[SEL_MSB:SEL_LSB] == SRC_PIN
		|=> failsafe_output_disable_o;
	endproperty
	a_failsafe: assert property (p_failsafe) else $error("failsafe not disabled"); // [RQ3]

	property p_rate_step;
		@(posedge clk_i) disable iff (!rst_b_i)
		st_reg.pa_pre == 9'h0 && st_reg.pa_rate[RATE_BIT] |=> st_reg.pa_pre == 9'(PWM_STEP_HI - 1);
	endproperty
	a_rate_step: assert property (p_rate_step) else $error("wrong PWM step length"); // [RQ4]

	property p_duty_zero;
		@(posedge clk_i) disable iff (!rst_b_i)
		st_reg.sel_act == SRC_PWM_A && st_reg.pa_hi == 8'h0 && st_reg.pa_lo == 8'h0 |=> !switch_on_o;
	endproperty
	a_duty_zero: assert property (p_duty_zero) else $error("zero duty drove switch"); // [RQ5] [RQ6]

	property p_duty_full;
		@(posedge clk_i) disable iff (!rst_b_i)
		st_reg.ctrl[ENABLE_BIT] && st_reg.sel_act == SRC_PWM_B
		&& {st_reg.pb_hi[1:0], st_reg.pb_lo} == DUTY_FULL |=> switch_on_o;
	endproperty
	a_duty_full: assert property (p_duty_full) else $error("full duty not on"); // [RQ7] [RQ6]

	property p_period_bound;
		@(posedge clk_i) disable iff (!rst_b_i)
		tick |=> st_reg.ta_cnt < period_ticks($past(st_reg.ta_cfg[PERIOD_MSB:PERIOD_LSB]));
	endproperty
	a_period_bound: assert property (p_period_bound) else $error("timer count past period"); // [RQ9]

	property p_width_hiz;
		@(posedge clk_i) disable iff (!rst_b_i)
		st_reg.sel_act == SRC_PERIODIC_B && st_reg.tb_cfg[WIDTH_MSB:WIDTH_LSB] == WIDTH_OFF
		|=> switch_high_z_o && !switch_on_o;
	endproperty
	a_width_hiz: assert property (p_width_hiz) else $error("zero width not high-z"); // [RQ10]

	property p_sel_hold;
		@(posedge clk_i) disable iff (!rst_b_i)
		!boundary |=> $stable(st_reg.sel_act);
	endproperty
	a_sel_hold: assert property (p_sel_hold) else $error("selector changed mid-period"); // [RQ11]
endmodule

// ===== tb/hss_load_model.sv
// Behavioural LED load that counts the cycles in which the switch sources current.
module hss_load_model
(
	// Clock and window clear.
	input wire logic clk_i,
	input wire logic clear_i,
	// Switch drive seen at the load.
	input wire logic switch_on_i,
	input wire logic switch_high_z_i,
	// Lit state and on-time count.
	output logic lit_o,
	output logic [15:0] on_count_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// A floating switch leaves the load dark whatever the drive level shows.
	assign lit_o = switch_on_i && !switch_high_z_i;
	always_ff @(posedge clk_i)
	begin
		if (clear_i)
			on_count_o <= 16'h0000;
		else if (lit_o)
			on_count_o <= on_count_o + 16'h0001;
	end
endmodule

// ===== tb/tb_high_side_switch_pwm_control.sv
// Self-checking bench for the high-side switch drive block.
module tb_high_side_switch_pwm_control;
	timeunit 1ns;
	timeprecision 1ps;
	import hss_pkg::*;
	logic clk_i = 1'b0;
	logic rst_b_i = 1'b0;
	reg_req_t req_i = '0;
	logic pin = 1'b0;
	logic clr = 1'b1;
	logic ck = 1'b0;
	logic [1:0] kind = 2'h0;
	logic [7:0] rdata_o;
	logic sw_on, sw_hz, fs_dis;
	logic [15:0] on_cnt, lo, hi;
	logic [7:0] q[$];
	logic [7:0] msk[11] = '{8'h00, MASK_SWITCH_CONTROL, MASK_RATE, MASK_DUTY_HIGH,
		MASK_DUTY_LOW, MASK_RATE, MASK_DUTY_HIGH, MASK_DUTY_LOW, MASK_PERIODIC,
		MASK_PERIODIC, 8'h00};
	int errors = 0;
	int n_tests = 0;
	int cycles = 0;
	int seed = 1175;
	int i;

	always #5 clk_i = ~clk_i;

	high_side_switch_pwm_control #(.TICK_CYCLES(4)) u_dut
	(
		.clk_i(clk_i), .rst_b_i(rst_b_i), .req_i(req_i), .rdata_o(rdata_o),
		.switch_control_pin_i(pin), .switch_on_o(sw_on), .switch_high_z_o(sw_hz),
		.failsafe_output_disable_o(fs_dis)
	);
	hss_load_model u_load
	(
		.clk_i(clk_i), .clear_i(clr), .switch_on_i(sw_on), .switch_high_z_i(sw_hz),
		.lit_o(), .on_count_o(on_cnt)
	);

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			errors++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic finish_test();
		if (errors == 0 && n_tests > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// Results are compared off the clock edge, once the design's updates have landed.
	always @(negedge clk_i)
	begin
		if (ck)
		begin
			case (kind)
				2'h0: check(rdata_o, q.pop_front());
				2'h1: check({5'h00, sw_on, sw_hz, fs_dis}, q.pop_front());
				default: check({7'h00, on_cnt >= lo && on_cnt <= hi}, q.pop_front());
			endcase
		end
	end

	always @(posedge clk_i)
	begin
		cycles++;
		if (cycles == 90000)
		begin
			errors++;
			finish_test();
		end
	end

	task automatic note(input logic [1:0] k, input logic [7:0] e);
		@(posedge clk_i);
		q.push_back(e);
		kind <= k;
		ck <= 1'b1;
		@(posedge clk_i);
		ck <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_i);
		req_i <= '{1'b1, a, d};
		@(posedge clk_i);
		req_i.wr <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk_i);
		req_i.addr <= a;
		note(2'h0, e);
	endtask

	task automatic reset_dut();
		@(posedge clk_i);
		rst_b_i <= 1'b0;
		repeat (4) @(posedge clk_i);
		rst_b_i <= 1'b1;
	endtask

	// Lets the load count for about 4001 cycles and checks the on-time lies in range.
	task automatic meas(input logic [15:0] l, input logic [15:0] h);
		@(posedge clk_i);
		clr <= 1'b0;
		repeat (4000) @(posedge clk_i);
		lo = l;
		hi = h;
		note(2'h2, 8'h01);
		clr <= 1'b1;
	endtask

	initial
	begin
		reset_dut();
		for (i = 0; i < 11; i++)
			rd(8'h1D + 8'(i), RESET_VALUE);
		for (i = 0; i < 11; i++)
		begin
			wr(8'h1D + 8'(i), 8'hFF);
			rd(8'h1D + 8'(i), msk[i]);
		end
		note(2'h1, 8'h00);
		reset_dut();
		note(2'h1, 8'h02);
		wr(ADDR_SWITCH_CONTROL, 8'h80);
		note(2'h1, 8'h04);
		wr(ADDR_SWITCH_CONTROL, 8'h60);
		note(2'h1, 8'h02);
		wr(ADDR_SWITCH_CONTROL, 8'hE0);
		note(2'h1, 8'h00);
		wr(ADDR_SWITCH_CONTROL, 8'hD0);
		for (i = 0; i < 12; i++)
		begin
			@(posedge clk_i);
			pin <= 1'($random(seed));
			repeat (3) @(posedge clk_i);
			note(2'h1, {5'h00, pin, 1'b0, 1'b1});
		end
		wr(ADDR_SWITCH_CONTROL, 8'h50);
		note(2'h1, 8'h03);
		// Duty 5 is the smallest the load is driven with, well clear of a single step.
		reset_dut();
		wr(ADDR_PWM_A_DUTY_LOW, 8'h05);
		wr(ADDR_SWITCH_CONTROL, 8'h90);
		meas(16'd2370, 16'd2460);
		reset_dut();
		wr(ADDR_PWM_A_RATE, 8'h80);
		wr(ADDR_PWM_A_DUTY_LOW, 8'h05);
		wr(ADDR_SWITCH_CONTROL, 8'h90);
		// The first step after reset runs at the reset rate, the next four at 400 Hz.
		meas(16'd1420, 16'd1470);
		wr(ADDR_PWM_A_DUTY_LOW, 8'h00);
		meas(16'd0, 16'd0);
		reset_dut();
		wr(ADDR_PWM_B_RATE, 8'h80);
		wr(ADDR_PWM_B_DUTY_HIGH, 8'h03);
		wr(ADDR_SWITCH_CONTROL, 8'hA0);
		meas(16'd3990, 16'd4010);
		wr(ADDR_PWM_B_DUTY_HIGH, 8'h00);
		meas(16'd0, 16'd0);
		wr(ADDR_PWM_B_DUTY_HIGH, 8'h03);
		wr(ADDR_PWM_B_DUTY_LOW, 8'hFF);
		meas(16'd3990, 16'd4010);
		reset_dut();
		wr(ADDR_PERIODIC_A, 8'h40);
		wr(ADDR_SWITCH_CONTROL, 8'hB0);
		meas(16'd390, 16'd410);
		reset_dut();
		wr(ADDR_PERIODIC_B, 8'h51);
		wr(ADDR_SWITCH_CONTROL, 8'hC0);
		meas(16'd1990, 16'd2010);
		wr(ADDR_PERIODIC_B, 8'hF1);
		meas(16'd3990, 16'd4010);
		wr(ADDR_PERIODIC_B, 8'h01);
		repeat (900) @(posedge clk_i);
		note(2'h1, 8'h02);
		finish_test();
	end
endmodule
